//--- shared/ppd_params.svh
// constants for the parallel phone intrusion detector
// assumes a 10 MHz system clock and an 8-bit register port
`ifndef PPD_PARAMS_SVH
`define PPD_PARAMS_SVH
// timebase
`define PPD_CLK_HZ 10000000
`define PPD_ONH_PERIOD_US 26660
`define PPD_TICK_US 40000
`define PPD_ONH_CYC (`PPD_ONH_PERIOD_US * (`PPD_CLK_HZ / 1000000))
`define PPD_TICK_CYC (`PPD_TICK_US * (`PPD_CLK_HZ / 1000000))
`define PPD_DIV200 5
// register offsets
`define PPD_A_ONH_THR 8'h11
`define PPD_A_OFH_THR 8'h12
`define PPD_A_METHOD 8'h13
`define PPD_A_STATUS 8'h14
`define PPD_A_BLK_TIME 8'h29
`define PPD_A_SUPPRESS 8'h33
`define PPD_A_REENABLE 8'h62
`define PPD_A_SETTLE 8'h82
`define PPD_A_LOOP 8'hDB
`define PPD_A_DEGLITCH 8'hDF
// field positions
`define PPD_B_ONSEL 3
`define PPD_B_OFFSEL 4
`define PPD_B_RESULT_CODE_MASTER_DISABLE 7
`define PPD_B_NLD 2
`define PPD_B_IND 1
`define PPD_B_ALT 6
// reset values and the timed blocking method code
`define PPD_R_AVL 5'h08
`define PPD_R_DVL 3'h2
`define PPD_R_DCL 3'h2
`define PPD_R_REF 5'h00
`define PPD_R_OFFSEL 1'b1
`define PPD_R_IST 4'h5
`define PPD_B_TIMED 2'h2
`endif

//--- shared/ppd_pkg.sv
// types for the parallel phone intrusion detector
// no assumptions beyond the matching params header
package ppd_pkg;
  // hook phase, on hook and off-hook, one-hot
  typedef enum logic [3:0] {
    ST_ONHOOK = 4'h1,
    ST_SETTLE = 4'h2,
    ST_RUN = 4'h4,
    ST_BLOCK = 4'h8
  } phase_t;
  // result codes toward the host
  typedef enum logic [1:0] {
    RC_INTR = 2'h0,
    RC_INTR_END = 2'h1,
    RC_NO_LINE = 2'h2,
    RC_LINE_BACK = 2'h3
  } rc_t;
  typedef struct packed {
    logic valid;
    rc_t code;
  } result_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage

//--- core/parallel_phone_intrusion_detector.sv
// parallel phone intrusion detector: on-hook and off-hook algorithms
// assumes a 5-bit loop sense code from an async front end and a
// same-clock hook state and dial start pulse from the modem core
//
// Overview of operation
// RQ1 - loop sense code reported in register
// RQ2 - on-hook select: absolute or differential
// RQ3 - absolute: intrusion when code below threshold
// RQ4 - absolute threshold resets to 25 V code
// RQ5 - differential every 26.66 ms, threshold two
// RQ6 - codes on intrusion start/end, status held
// RQ7 - zero code: no-line code and status
// RQ8 - master disable gates codes, status continues
// RQ9 - alternate suppress: no codes, status frozen (status frozen on hook only; off hook the status still updates)
// RQ10 - wait settling time before off-hook algorithms
// RQ11 - select bit and rate pick algorithm
// RQ12 - differential one: 200 ms, 800 ms lookback
// RQ13 - off-hook differential threshold defaults two
// RQ14 - deglitch passes only repeated samples
// RQ15 - differential two: rate-scaled period, lookback
// RQ16 - host should program one second rate
// RQ17 - host preloads reference before off hook
// RQ18 - on hook, save last clean sample
// RQ19 - reference cleared on reset, reconnect
// RQ20 - blocking method timed window after dialing
// RQ21 - compare samples across the blocking window
// RQ22 - off-hook absolute: code below reference
// RQ23 - samples held, intervals from counters
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "ppd_params.svh"
module parallel_phone_intrusion_detector #(
  parameter int ONH_CYC = `PPD_ONH_CYC,
  parameter int TICK_CYC = `PPD_TICK_CYC
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire ppd_pkg::bus_req_t bus_req_in,
  input wire logic [4:0] loop_sense_code_in,
  input wire logic off_hook_in,
  input wire logic dial_start_in,
  output ppd_pkg::result_t result_out,
  output logic intrusion_status_out,
  output logic no_line_status_out,
  output logic [7:0] rdata_out
);
  import ppd_pkg::*;

  // =========================================================
  // state
  // =========================================================
  logic [4:0] s1_ff, s2_ff, s3_ff; // pin synchroniser
  logic [4:0] lv_ff, nxt_lv; // accepted loop sense code
  logic [18:0] onh_cnt_ff, nxt_onh_cnt; // 26.66 ms divider
  logic [18:0] t40_cnt_ff, nxt_t40_cnt; // 40 ms divider
  logic [2:0] div5_ff, nxt_div5; // 200 ms prescale
  logic [6:0] dg_cnt_ff, nxt_dg_cnt; // deglitch period
  logic [3:0] stl_ff, nxt_stl; // settling count
  logic [7:0] blk_ff, nxt_blk; // blocking count
  logic [4:0] avl_ff, nxt_avl, ref_ff, nxt_ref;
  logic [2:0] dvl_ff, nxt_dvl, dcl_ff, nxt_dcl;
  logic onsel_ff, nxt_onsel, offsel_ff, nxt_offsel;
  logic result_code_master_disable_ff, nxt_result_code_master_disable, alt_ff, nxt_alt;
  logic [3:0] reen_ff, nxt_reen, ist_ff, nxt_ist;
  logic [7:0] btime_ff, nxt_btime;
  logic [1:0] ib_ff, nxt_ib;
  logic [6:0] deglitch_rate_ff, nxt_deglitch_rate;
  phase_t phase_ff, nxt_phase;
  logic ind_ff, nxt_ind, nld_ff, nxt_nld;
  logic [4:0] prev_ff, nxt_prev; // on-hook previous sample
  logic [4:0] hist_ff [4]; // off-hook history, [0] newest
  logic [4:0] nxt_hist [4];
  logic [4:0] good_ff, nxt_good; // last clean sample
  logic [4:0] dgl_ff, nxt_dgl; // last deglitch sample
  logic [4:0] pre_ff, nxt_pre; // sample before blocking
  result_t res_ff, nxt_res;
  logic [7:0] rdata_ff, nxt_rdata;

  // combinational helpers
  logic t40, t200, on_tick, dg_tick, diff1, diff2, take, emit;
  rc_t ecode;
  logic [4:0] old;

  // =========================================================
  // helpers
  // =========================================================
  // true when a exceeds b by more than thr
  function automatic logic drop(input logic [4:0] a,
                                input logic [4:0] b,
                                input logic [2:0] thr);
    drop = (a > b) && ((a - b) > {2'h0, thr});
  endfunction

  // =========================================================
  // next state
  // =========================================================
  // one process computes every next value except the synchroniser stages
  always_comb
  begin
    nxt_lv = lv_ff;
    nxt_onh_cnt = onh_cnt_ff + 19'h1;
    nxt_t40_cnt = t40_cnt_ff + 19'h1;
    nxt_div5 = div5_ff;
    nxt_dg_cnt = dg_cnt_ff;
    nxt_stl = stl_ff;
    nxt_blk = blk_ff;
    nxt_avl = avl_ff;
    nxt_ref = ref_ff;
    nxt_dvl = dvl_ff;
    nxt_dcl = dcl_ff;
    nxt_onsel = onsel_ff;
    nxt_offsel = offsel_ff;
    nxt_result_code_master_disable = result_code_master_disable_ff;
    nxt_alt = alt_ff;
    nxt_reen = reen_ff;
    nxt_ist = ist_ff;
    nxt_btime = btime_ff;
    nxt_ib = ib_ff;
    nxt_deglitch_rate = deglitch_rate_ff;
    nxt_phase = phase_ff;
    nxt_ind = ind_ff;
    nxt_nld = nld_ff;
    nxt_prev = prev_ff;
    nxt_hist = hist_ff;
    nxt_good = good_ff;
    nxt_dgl = dgl_ff;
    nxt_pre = pre_ff;
    nxt_rdata = 8'h00;
    emit = 1'b0;
    ecode = RC_INTR;
    take = 1'b0;
    old = 5'h00;
    // accept a code once the last two stages agree
    if (s2_ff == s3_ff)
    begin
      nxt_lv = s3_ff;
    end
    // periodic intervals from counters
    on_tick = onh_cnt_ff == 19'(ONH_CYC - 1); // RQ23
    t40 = t40_cnt_ff == 19'(TICK_CYC - 1); // RQ23
    t200 = t40 && (div5_ff == 3'(`PPD_DIV200 - 1));
    dg_tick = t40 && (dg_cnt_ff == deglitch_rate_ff - 7'h1);
    if (on_tick)
    begin
      nxt_onh_cnt = 19'h0;
    end
    if (t40)
    begin
      nxt_t40_cnt = 19'h0;
      nxt_div5 = t200 ? 3'h0 : div5_ff + 3'h1;
      nxt_dg_cnt = dg_tick ? 7'h0 : dg_cnt_ff + 7'h1;
    end
    // algorithm choice
    diff1 = offsel_ff && (deglitch_rate_ff == 7'h0); // RQ11
    diff2 = offsel_ff && (deglitch_rate_ff != 7'h0); // RQ11
    // deglitch: forward only a repeated sample
    if (dg_tick)
    begin
      nxt_dgl = lv_ff;
    end
    // register writes
    if (bus_req_in.wr)
    begin
      unique case (bus_req_in.addr)
        `PPD_A_ONH_THR:
        begin
          nxt_avl = bus_req_in.wdata[4:0];
          nxt_dvl = bus_req_in.wdata[7:5];
        end
        `PPD_A_OFH_THR:
        begin
          nxt_ref = bus_req_in.wdata[4:0];
          nxt_dcl = bus_req_in.wdata[7:5];
        end
        `PPD_A_METHOD:
        begin
          nxt_onsel = bus_req_in.wdata[`PPD_B_ONSEL];
          nxt_offsel = bus_req_in.wdata[`PPD_B_OFFSEL];
        end
        `PPD_A_STATUS: nxt_result_code_master_disable = bus_req_in.wdata[`PPD_B_RESULT_CODE_MASTER_DISABLE];
        `PPD_A_BLK_TIME: nxt_btime = bus_req_in.wdata;
        `PPD_A_SUPPRESS: nxt_alt = bus_req_in.wdata[`PPD_B_ALT];
        `PPD_A_REENABLE: nxt_reen = bus_req_in.wdata[3:0];
        `PPD_A_SETTLE:
        begin
          nxt_ist = bus_req_in.wdata[7:4];
          nxt_ib = bus_req_in.wdata[1:0];
        end
        `PPD_A_DEGLITCH: nxt_deglitch_rate = bus_req_in.wdata[6:0];
        default: ; // unmapped writes ignored
      endcase
    end
    // hook phase machine; hardware updates win over writes
    unique case (phase_ff)
      ST_ONHOOK:
      begin
        if (off_hook_in)
        begin
          nxt_phase = ST_SETTLE;
          nxt_stl = 4'h0;
          // restart the timebase so settling starts at the hook edge
          nxt_t40_cnt = 19'h0; // RQ10
          nxt_div5 = 3'h0;
          nxt_dg_cnt = 7'h0;
        end
        else if (!alt_ff) // RQ9
        begin
          if (lv_ff == 5'h00 && !nld_ff)
          begin
            nxt_nld = 1'b1; // RQ7
            emit = 1'b1;
            ecode = RC_NO_LINE;
          end
          else if (lv_ff != 5'h00 && nld_ff)
          begin
            nxt_nld = 1'b0; // RQ7
            nxt_ref = 5'h00; // RQ19
            emit = 1'b1;
            ecode = RC_LINE_BACK;
          end
          else if (on_tick)
          begin
            nxt_prev = lv_ff; // RQ5
            if (!onsel_ff) // RQ2
            begin
              nxt_ind = lv_ff < avl_ff; // RQ3
            end
            else if (drop(prev_ff, lv_ff, dvl_ff))
            begin
              nxt_ind = 1'b1; // RQ5
            end
            else if (drop(lv_ff, prev_ff, dvl_ff))
            begin
              nxt_ind = 1'b0; // RQ5
            end
            if (nxt_ind != ind_ff)
            begin
              emit = 1'b1; // RQ6
              ecode = nxt_ind ? RC_INTR : RC_INTR_END;
            end
          end
        end
      end
      ST_SETTLE:
      begin
        if (t200)
        begin
          nxt_stl = stl_ff + 4'h1; // RQ10
        end
        if (t200 && (stl_ff + 4'h1 >= ist_ff))
        begin
          nxt_phase = ST_RUN;
          // preset reference or first sample
          for (int i = 0; i < 4; i++)
          begin
            nxt_hist[i] = (ref_ff != 5'h00) ? ref_ff : lv_ff;
          end
          nxt_good = nxt_hist[0];
        end
      end
      ST_RUN:
      begin
        if (dial_start_in && diff2 && ib_ff == `PPD_B_TIMED)
        begin
          nxt_phase = ST_BLOCK; // RQ20
          nxt_blk = 8'h00;
          nxt_pre = hist_ff[0]; // RQ21
          // window measured from the dial edge, not a free phase
          nxt_t40_cnt = 19'h0; // RQ20
          nxt_div5 = 3'h0;
        end
        else if (!offsel_ff)
        begin
          if (t40)
          begin
            nxt_ind = lv_ff < ref_ff; // RQ22
            if (!nxt_ind)
            begin
              nxt_good = lv_ff;
            end
          end
        end
        else
        begin
          take = (diff1 && t200) // RQ12
            || (diff2 && dg_tick && lv_ff == dgl_ff); // RQ14
          old = diff1 ? hist_ff[3] : hist_ff[1]; // RQ15
          if (take)
          begin
            if (!ind_ff && drop(old, lv_ff, dcl_ff))
            begin
              nxt_ind = 1'b1; // RQ12
            end
            else if (ind_ff && drop(lv_ff, old, dcl_ff))
            begin
              nxt_ind = 1'b0; // RQ12
            end
            if (!nxt_ind)
            begin
              nxt_good = lv_ff;
            end
            nxt_hist[0] = lv_ff;
            for (int i = 1; i < 4; i++)
            begin
              nxt_hist[i] = hist_ff[i - 1];
            end
          end
        end
        if (nxt_ind != ind_ff)
        begin
          emit = 1'b1; // RQ6
          ecode = nxt_ind ? RC_INTR : RC_INTR_END;
        end
      end
      ST_BLOCK:
      begin
        if (t200)
        begin
          nxt_blk = blk_ff + 8'h1;
        end
        if (t200 && (blk_ff + 8'h1 >= btime_ff))
        begin
          nxt_phase = ST_RUN;
          for (int i = 0; i < 4; i++)
          begin
            nxt_hist[i] = lv_ff;
          end
          if (!ind_ff && drop(pre_ff, lv_ff, dcl_ff))
          begin
            nxt_ind = 1'b1; // RQ21
            emit = 1'b1;
            ecode = RC_INTR;
          end
        end
      end
      default: nxt_phase = ST_ONHOOK;
    endcase
    // back on hook from any off-hook phase
    if (phase_ff != ST_ONHOOK && !off_hook_in)
    begin
      nxt_phase = ST_ONHOOK;
      nxt_ref = good_ff; // RQ18
      nxt_prev = lv_ff;
    end
    // code gating: alternate suppress, then master disable
    nxt_res.valid = emit && !alt_ff // RQ9
      && (!result_code_master_disable_ff || reen_ff[ecode]); // RQ8
    nxt_res.code = ecode;
    // read data, one cycle after the strobe
    if (bus_req_in.rd)
    begin
      unique case (bus_req_in.addr)
        `PPD_A_ONH_THR: nxt_rdata = {dvl_ff, avl_ff};
        `PPD_A_OFH_THR: nxt_rdata = {dcl_ff, ref_ff};
        `PPD_A_METHOD: nxt_rdata = {3'h0, offsel_ff, onsel_ff, 3'h0};
        `PPD_A_STATUS:
          nxt_rdata = {result_code_master_disable_ff, 4'h0, nld_ff, ind_ff, 1'b0};
        `PPD_A_BLK_TIME: nxt_rdata = btime_ff;
        `PPD_A_SUPPRESS: nxt_rdata = {1'b0, alt_ff, 6'h00};
        `PPD_A_REENABLE: nxt_rdata = {4'h0, reen_ff};
        `PPD_A_SETTLE: nxt_rdata = {ist_ff, 2'h0, ib_ff};
        `PPD_A_LOOP: nxt_rdata = {3'h0, lv_ff}; // RQ1
        `PPD_A_DEGLITCH: nxt_rdata = {1'b0, deglitch_rate_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // =========================================================
  // registers
  // =========================================================
  // registers only; constants under reset
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s1_ff <= 5'h00;
      s2_ff <= 5'h00;
      s3_ff <= 5'h00;
      lv_ff <= 5'h00;
      onh_cnt_ff <= 19'h0; // RQ23
      t40_cnt_ff <= 19'h0;
      div5_ff <= 3'h0;
      dg_cnt_ff <= 7'h0;
      stl_ff <= 4'h0;
      blk_ff <= 8'h00;
      avl_ff <= `PPD_R_AVL; // RQ4
      ref_ff <= `PPD_R_REF; // RQ19
      dvl_ff <= `PPD_R_DVL; // RQ5
      dcl_ff <= `PPD_R_DCL; // RQ13
      onsel_ff <= 1'b0;
      offsel_ff <= `PPD_R_OFFSEL;
      result_code_master_disable_ff <= 1'b0;
      alt_ff <= 1'b0;
      reen_ff <= 4'h0;
      ist_ff <= `PPD_R_IST; // RQ10
      btime_ff <= 8'h00;
      ib_ff <= 2'h0;
      deglitch_rate_ff <= 7'h00;
      phase_ff <= ST_ONHOOK;
      ind_ff <= 1'b0;
      nld_ff <= 1'b0;
      prev_ff <= 5'h00;
      hist_ff <= '{default: 5'h00};
      good_ff <= 5'h00;
      dgl_ff <= 5'h00;
      pre_ff <= 5'h00;
      res_ff <= '0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      s1_ff <= loop_sense_code_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lv_ff <= nxt_lv;
      onh_cnt_ff <= nxt_onh_cnt;
      t40_cnt_ff <= nxt_t40_cnt;
      div5_ff <= nxt_div5;
      dg_cnt_ff <= nxt_dg_cnt;
      stl_ff <= nxt_stl;
      blk_ff <= nxt_blk;
      avl_ff <= nxt_avl;
      ref_ff <= nxt_ref;
      dvl_ff <= nxt_dvl;
      dcl_ff <= nxt_dcl;
      onsel_ff <= nxt_onsel;
      offsel_ff <= nxt_offsel;
      result_code_master_disable_ff <= nxt_result_code_master_disable;
      alt_ff <= nxt_alt;
      reen_ff <= nxt_reen;
      ist_ff <= nxt_ist;
      btime_ff <= nxt_btime;
      ib_ff <= nxt_ib;
      deglitch_rate_ff <= nxt_deglitch_rate;
      phase_ff <= nxt_phase;
      ind_ff <= nxt_ind;
      nld_ff <= nxt_nld;
      prev_ff <= nxt_prev;
      hist_ff <= nxt_hist;
      good_ff <= nxt_good;
      dgl_ff <= nxt_dgl;
      pre_ff <= nxt_pre;
      res_ff <= nxt_res;
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs straight from flip-flops
  assign result_out = res_ff;
  assign intrusion_status_out = ind_ff;
  assign no_line_status_out = nld_ff;
  assign rdata_out = rdata_ff;

  // =========================================================
  // checks
  // =========================================================
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_alt_no_code: assert property ( // RQ9
    res_ff.valid |-> !$past(alt_ff))
    else $error("code sent while suppressed");
  a_result_code_master_disable_gate: assert property ( // RQ8
    res_ff.valid && $past(result_code_master_disable_ff) |-> $past(reen_ff[ecode]))
    else $error("code sent under master disable");
  a_noline_set: assert property ( // RQ7
    phase_ff == ST_ONHOOK && !off_hook_in && !alt_ff
    && lv_ff == 5'h00 |=> nld_ff)
    else $error("no-line status not set");
  a_abs_onhook: assert property ( // RQ3
    phase_ff == ST_ONHOOK && !off_hook_in && !alt_ff && !onsel_ff
    && on_tick && lv_ff != 5'h00 && !nld_ff
    |=> ind_ff == ($past(lv_ff) < $past(avl_ff)))
    else $error("absolute on-hook result wrong");
  a_settle_quiet: assert property ( // RQ10
    phase_ff == ST_SETTLE |=> $stable(ind_ff))
    else $error("intrusion changed while settling");
  a_ref_clear: assert property ( // RQ19
    phase_ff == ST_ONHOOK && !off_hook_in && !alt_ff && nld_ff
    && lv_ff != 5'h00 ##1 !bus_req_in.wr |-> ref_ff == 5'h00)
    else $error("reference kept after reconnect");
  a_ref_save: assert property ( // RQ18
    phase_ff != ST_ONHOOK && !off_hook_in
    |=> ref_ff == $past(good_ff) && phase_ff == ST_ONHOOK)
    else $error("reference not saved on hook");
  a_block_hold: assert property ( // RQ20
    phase_ff == ST_BLOCK && !t200 && off_hook_in |=> $stable(ind_ff))
    else $error("intrusion changed while blocked");
  a_read_once: assert property ( // RQ1
    !$past(bus_req_in.rd) |-> rdata_ff == 8'h00)
    else $error("read data outside its cycle");
endmodule

//--- tb/line_front_end_model.sv
// line sense front end model: hands the detector its loop sense code
// assumes the bench sets the line voltage and loop current codes
`timescale 1ns/1ps
module line_front_end_model (
  input wire logic off_hook_in,
  input wire logic [4:0] volt_code_in,
  input wire logic [4:0] curr_code_in,
  output logic [4:0] loop_sense_code_out
);
  // ==========================================
  // sense path
  // voltage while on hook, current while off hook
  // delayed off the clock, the code is asynchronous to the detector
  always @(off_hook_in or volt_code_in or curr_code_in)
    loop_sense_code_out <= #37 off_hook_in ? curr_code_in : volt_code_in;
  // line absent until the bench says otherwise
  initial loop_sense_code_out = 5'h00;
endmodule

//--- tb/parallel_phone_intrusion_detector_tb.sv
// testbench for the intrusion detector: register port and line events
// assumes the front end model and shortened on-hook and tick periods
`timescale 1ns/1ps
module parallel_phone_intrusion_detector_tb;
  import ppd_pkg::*;
  // ==========================================
  // signals
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  bus_req_t req = '0; // register port request
  logic off_hook = 1'b0; // hook state
  logic dial = 1'b0; // dial start pulse
  logic [4:0] volt = 5'h00; // line voltage code, line absent
  logic [4:0] curr = 5'h14; // loop current code
  logic [4:0] lsc; // code from the front end
  result_t res;
  logic intrusion_status;
  logic no_line_status;
  logic [7:0] rdata;
  rc_t rq[$]; // result codes in order of arrival
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0; // cycle count for the timeout
  // ==========================================
  // clock, front end and design
  always #50 sys_clk_in = ~sys_clk_in;
  line_front_end_model fe (
    .off_hook_in(off_hook),
    .volt_code_in(volt),
    .curr_code_in(curr),
    .loop_sense_code_out(lsc)
  );
  parallel_phone_intrusion_detector #(.ONH_CYC(20), .TICK_CYC(30)) dut (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .bus_req_in(req),
    .loop_sense_code_in(lsc),
    .off_hook_in(off_hook),
    .dial_start_in(dial),
    .result_out(res),
    .intrusion_status_out(intrusion_status),
    .no_line_status_out(no_line_status),
    .rdata_out(rdata)
  );
  // ==========================================
  // result monitor and timeout
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (res.valid === 1'b1)
      rq.push_back(res.code);
    if (cyc == 30000)
    begin
      num_errors++;
      test_done();
    end
  end
  // ==========================================
  // tasks
  // verdict and end of run
  task automatic test_done();
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // compare one value
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in);
    req.wr <= 1'b0;
  endtask
  // one-cycle read strobe, data in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                        input string what);
    @(posedge sys_clk_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in);
    req.rd <= 1'b0;
    #1;
    check(rdata, exp, what);
  endtask
  // new line codes and hook state
  task automatic line(input logic [4:0] v, input logic [4:0] c,
                      input logic h);
    @(posedge sys_clk_in);
    volt <= v;
    curr <= c;
    off_hook <= h;
  endtask
  // next result code within a bound
  task automatic exp_code(input rc_t c, input int lim, input string what);
    int n;
    n = 0;
    while (rq.size() == 0 && n < lim)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    if (rq.size() == 0)
      check(8'hFF, {6'h00, c}, what);
    else
      check({6'h00, rq.pop_front()}, {6'h00, c}, what);
  endtask
  // no result code for a while
  task automatic quiet(input int n);
    repeat (n) @(posedge sys_clk_in);
    check(8'(rq.size()), 8'h00, "result code count");
  endtask
  // let things settle, forget the codes
  task automatic flush(input int n);
    repeat (n) @(posedge sys_clk_in);
    rq.delete();
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    // defaults and an unmapped place
    rd_chk(8'h11, 8'h48, "onhook thresholds");
    rd_chk(8'h12, 8'h40, "offhook threshold and reference");
    rd_chk(8'h13, 8'h10, "method select");
    rd_chk(8'h82, 8'h50, "settle and blocking");
    rd_chk(8'h55, 8'h00, "unmapped address");
    // line absent, then present
    exp_code(RC_NO_LINE, 100, "no line code");
    rd_chk(8'h14, 8'h04, "status no line");
    line(5'h11, 5'h14, 1'b0);
    exp_code(RC_LINE_BACK, 100, "line back code");
    check({7'h00, no_line_status}, 8'h00, "no line status");
    rd_chk(8'hDB, 8'h11, "loop sense code");
    // on-hook absolute, threshold boundary
    line(5'h08, 5'h14, 1'b0);
    quiet(80);
    line(5'h05, 5'h14, 1'b0);
    exp_code(RC_INTR, 100, "intrusion code");
    check({7'h00, intrusion_status}, 8'h01, "intrusion status");
    line(5'h11, 5'h14, 1'b0);
    exp_code(RC_INTR_END, 100, "intrusion end code");
    check({7'h00, intrusion_status}, 8'h00, "intrusion status");
    // master disable, status keeps going, selective enable
    wr(8'h14, 8'h80);
    wr(8'h62, 8'h00);
    line(5'h05, 5'h14, 1'b0);
    quiet(100);
    rd_chk(8'h14, 8'h82, "status under disable");
    line(5'h11, 5'h14, 1'b0);
    quiet(100);
    wr(8'h62, 8'h01);
    line(5'h05, 5'h14, 1'b0);
    exp_code(RC_INTR, 100, "reenabled code");
    line(5'h11, 5'h14, 1'b0);
    quiet(100);
    wr(8'h14, 8'h00);
    wr(8'h62, 8'h00);
    // alternate suppress freezes status
    wr(8'h33, 8'h40);
    line(5'h05, 5'h14, 1'b0);
    quiet(100);
    check({7'h00, intrusion_status}, 8'h00, "frozen status");
    line(5'h11, 5'h14, 1'b0);
    flush(60);
    wr(8'h33, 8'h00);
    // on-hook differential, step of two then three
    wr(8'h13, 8'h18);
    line(5'h0F, 5'h14, 1'b0);
    quiet(100);
    line(5'h0C, 5'h14, 1'b0);
    exp_code(RC_INTR, 100, "differential intrusion");
    line(5'h0F, 5'h14, 1'b0);
    exp_code(RC_INTR_END, 100, "differential end");
    wr(8'h13, 8'h10);
    wr(8'h82, 8'h10);
    flush(60);
    // differential one: drop inside settling is not seen
    line(5'h11, 5'h14, 1'b1);
    repeat (50) @(posedge sys_clk_in);
    line(5'h11, 5'h11, 1'b1);
    quiet(900);
    line(5'h11, 5'h0E, 1'b1);
    exp_code(RC_INTR, 400, "differential one intrusion");
    line(5'h11, 5'h0E, 1'b0);
    flush(100);
    rd_chk(8'h12, 8'h51, "saved reference");
    // disconnect and reconnect clears the reference
    line(5'h00, 5'h14, 1'b0);
    flush(100);
    line(5'h11, 5'h14, 1'b0);
    flush(100);
    rd_chk(8'h12, 8'h40, "cleared reference");
    // differential two with a preset reference
    wr(8'hDF, 8'h02);
    wr(8'h12, 8'h54);
    line(5'h11, 5'h10, 1'b1);
    exp_code(RC_INTR, 600, "preset reference intrusion");
    line(5'h11, 5'h14, 1'b1);
    exp_code(RC_INTR_END, 400, "differential two end");
    // short glitch is filtered
    repeat (300) @(posedge sys_clk_in);
    line(5'h11, 5'h0E, 1'b1);
    repeat (20) @(posedge sys_clk_in);
    line(5'h11, 5'h14, 1'b1);
    quiet(500);
    // timed blocking after dialing, sustained drop caught after it
    wr(8'h29, 8'h02);
    wr(8'h82, 8'h12);
    @(posedge sys_clk_in);
    dial <= 1'b1;
    @(posedge sys_clk_in);
    dial <= 1'b0;
    line(5'h11, 5'h10, 1'b1);
    quiet(250);
    exp_code(RC_INTR, 500, "intrusion across blocking");
    line(5'h11, 5'h10, 1'b0);
    flush(100);
    // off-hook absolute against the reference field
    wr(8'h13, 8'h00);
    wr(8'h12, 8'h52);
    wr(8'h82, 8'h10);
    line(5'h11, 5'h14, 1'b1);
    quiet(300);
    line(5'h11, 5'h11, 1'b1);
    exp_code(RC_INTR, 200, "absolute intrusion");
    line(5'h11, 5'h12, 1'b1);
    exp_code(RC_INTR_END, 200, "absolute end");
    line(5'h11, 5'h12, 1'b0);
    flush(50);
    test_done();
  end
endmodule
